//--- common/eid_defs.svh
// Register offsets, field positions, reset values and sizes for the external interrupt detector
`ifndef EID_DEFS_SVH
`define EID_DEFS_SVH
`define EID_OFS_FLAG     8'h00
`define EID_OFS_ENABLE   8'h04
`define EID_OFS_SENSE    8'h08
`define EID_OFS_STATUS   8'h0c
`define EID_OFS_MASK     8'h10
`define EID_RST_REG      8'h00
`define EID_NUM_INPUTS   6
`define EID_FLAG_RO_MSB  7
`define EID_FLAG_RO_LSB  6
`define EID_VEC_BASE     5'h0c
`define EID_STAT_SET_BIT 0
`define EID_STAT_CLR_BIT 1
`define EID_RESP_OKAY    2'h0
`define EID_RESP_SLVERR  2'h2
`endif

//--- common/eid_pkg.sv
// Types shared by the external interrupt detector
package eid_pkg;
    typedef logic [7:0] eid_reg_t;
    typedef struct packed {
        logic [7:0] addr;
        logic       valid;
    } eid_req_s;
    typedef struct packed {
        logic       valid;
        logic [4:0] vector;
    } eid_irq_s;
endpackage

//--- hdl/eid_detect.sv
// External interrupt detector with AXI4-Lite register slave
`timescale 1ns/100ps
`include "eid_defs.svh"

module eid_detect
    import eid_pkg::*;
#(
    parameter int NUM_IN = `EID_NUM_INPUTS
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              hw_standby,
    input  wire logic [NUM_IN-1:0] ext_int_input_n,
    input  wire logic [NUM_IN-1:0] svc_ack,
    output logic [NUM_IN-1:0]      irq_req,
    output eid_irq_s               irq_out,
    output logic                   irq,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    logic [NUM_IN-1:0] sync1_r;
    logic [NUM_IN-1:0] sync2_r;
    logic [NUM_IN-1:0] prev_r;
    logic [NUM_IN-1:0] flag_r;
    logic [NUM_IN-1:0] armed_r;
    logic [NUM_IN-1:0] set_ev;
    logic [NUM_IN-1:0] clr_ev;
    logic [NUM_IN-1:0] sw_clr;
    eid_reg_t          enable_r;
    eid_reg_t          sense_r;
    logic [1:0]        stat_r;
    logic [1:0]        mask_r;
    logic              hold_rst;
    eid_req_s          aw_r;
    logic [31:0]       wd_r;
    logic [3:0]        ws_r;
    logic              w_have_r;
    logic              do_write;
    logic              do_read;
    logic [7:0]        rd_val;
    logic              rd_hit;
    logic              wr_hit;
    eid_reg_t          flag_view;
    logic              sb1_r;
    logic              sb2_r;
    logic              wr_lane0;
    logic              wr_flag_sel;
    logic              wr_enable_sel;
    logic              wr_sense_sel;
    logic              wr_mask_sel;
    logic              rd_flag_sel;
    logic              rd_status_sel;
    logic              stat_set_ev;
    logic              stat_clr_ev;
    logic [NUM_IN-1:0] fall_ev;
    logic [NUM_IN-1:0] low_ev;
    logic [NUM_IN-1:0] flag_nxt;
    logic [NUM_IN-1:0] armed_nxt;
    logic [NUM_IN-1:0] req_nxt;
    logic              any_req;
    logic [4:0]        vec_nxt;

    // Standby comes from a pin, so it passes two stages like the request pins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sb1_r <= 1'b0;
            sb2_r <= 1'b0;
        end else begin
            sb1_r <= hw_standby;
            sb2_r <= sb1_r;
        end
    end

    assign hold_rst = srst | sb2_r;

    // Register strobes, decoded once so every register sees the same terms
    assign wr_lane0      = do_write & ws_r[0];
    assign wr_flag_sel   = wr_lane0 & (aw_r.addr == `EID_OFS_FLAG);
    assign wr_enable_sel = wr_lane0 & (aw_r.addr == `EID_OFS_ENABLE);
    assign wr_sense_sel  = wr_lane0 & (aw_r.addr == `EID_OFS_SENSE);
    assign wr_mask_sel   = wr_lane0 & (aw_r.addr == `EID_OFS_MASK);
    assign rd_flag_sel   = do_read & (s_axi_araddr == `EID_OFS_FLAG);
    assign rd_status_sel = do_read & (s_axi_araddr == `EID_OFS_STATUS);

    // Two stages before any logic; the pin direction plays no part here
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r  <= '1;
        end else begin
            sync1_r <= ext_int_input_n;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Write channel capture: address and data may arrive in either order
    assign s_axi_awready = ~aw_r.valid & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
    assign do_write      = aw_r.valid & w_have_r & ~s_axi_bvalid;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_r.valid <= 1'b1;
            aw_r.addr  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_r.valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            w_have_r <= 1'b0;
            wd_r     <= '0;
            ws_r     <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wd_r     <= s_axi_wdata;
            ws_r     <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    always_comb begin
        unique case (aw_r.addr)
            `EID_OFS_FLAG, `EID_OFS_ENABLE, `EID_OFS_SENSE,
            `EID_OFS_STATUS, `EID_OFS_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // The code is only looked at while bvalid stands, so it needs no clearing
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_bresp <= `EID_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bresp <= wr_hit ? `EID_RESP_OKAY : `EID_RESP_SLVERR;
        end
    end

    // Software clear needs lane 0, a zero bit, and a prior read as one
    always_comb begin
        if (wr_flag_sel) begin
            sw_clr = ~wd_r[NUM_IN-1:0] & armed_r;
        end else begin
            sw_clr = '0;
        end
    end

    // Per-input set and clear terms
    generate
        for (genvar i = 0; i < NUM_IN; i++) begin : g_in
            assign fall_ev[i] = prev_r[i] & ~sync2_r[i];
            assign low_ev[i]  = ~sync2_r[i];
            assign set_ev[i] = sense_r[i] ? fall_ev[i]
                                          : low_ev[i];
            assign clr_ev[i] = sw_clr[i]
                             | (svc_ack[i] & sense_r[i])
                             | (svc_ack[i] & ~sense_r[i] & sync2_r[i]);
        end
    endgenerate

    assign flag_nxt = set_ev | (flag_r & ~clr_ev);

    // Set wins over any clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Arming tracks which flags software has seen as one
    always_comb begin
        if (rd_flag_sel) begin
            armed_nxt = flag_r;
        end else begin
            armed_nxt = armed_r & flag_r & ~sw_clr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            armed_r <= '0;
        end else begin
            armed_r <= armed_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            enable_r <= `EID_RST_REG;
        end else if (wr_enable_sel) begin
            enable_r <= wd_r[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            sense_r <= `EID_RST_REG;
        end else if (wr_sense_sel) begin
            sense_r <= wd_r[7:0];
        end
    end

    // Summary status: bit 0 any flag newly set, bit 1 any flag cleared
    assign stat_set_ev = |(set_ev & ~flag_r);
    assign stat_clr_ev = |(clr_ev & flag_r & ~set_ev);

    // An event in the cycle of the clearing read wins, so none is lost
    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            stat_r <= '0;
        end else begin
            if (stat_set_ev) begin
                stat_r[`EID_STAT_SET_BIT] <= 1'b1;
            end else if (rd_status_sel) begin
                stat_r[`EID_STAT_SET_BIT] <= 1'b0;
            end
            if (stat_clr_ev) begin
                stat_r[`EID_STAT_CLR_BIT] <= 1'b1;
            end else if (rd_status_sel) begin
                stat_r[`EID_STAT_CLR_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            mask_r <= '0;
        end else if (wr_mask_sel) begin
            mask_r <= wd_r[1:0];
        end
    end

    // Read channel
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_read       = s_axi_arvalid & s_axi_arready;
    assign flag_view     = {2'b00, flag_r};

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `EID_OFS_FLAG:   rd_val = flag_view;
            `EID_OFS_ENABLE: rd_val = enable_r;
            `EID_OFS_SENSE:  rd_val = sense_r;
            `EID_OFS_STATUS: rd_val = {6'h00, stat_r};
            `EID_OFS_MASK:   rd_val = {6'h00, mask_r};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Data and code are captured with the address and held until the next read
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `EID_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? `EID_RESP_OKAY : `EID_RESP_SLVERR;
        end
    end

    // Lowest-numbered request wins the vector; lower number, higher priority
    assign req_nxt = flag_r & enable_r[NUM_IN-1:0];
    assign any_req = |req_nxt;

    always_comb begin
        vec_nxt = `EID_VEC_BASE;
        for (int k = NUM_IN - 1; k >= 0; k--) begin
            if (req_nxt[k]) begin
                vec_nxt = 5'(`EID_VEC_BASE + k);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            irq_req <= '0;
        end else begin
            irq_req <= req_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            irq_out <= '0;
        end else begin
            irq_out.valid  <= any_req;
            irq_out.vector <= vec_nxt;
        end
    end

    // The summary line is kept apart from the per-input requests
    always_ff @(posedge clk_sys) begin
        if (hold_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

endmodule // eid_detect

//--- sim/eid_detect_checker.sv
// Port assertions for the external interrupt detector
`timescale 1ns/100ps
module eid_detect_checker
    import eid_pkg::*;
#(parameter int NUM_IN = 6) (
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic              hw_standby,
    input wire logic [NUM_IN-1:0] ext_int_input_n,
    input wire logic [NUM_IN-1:0] svc_ack,
    input wire logic [NUM_IN-1:0] irq_req,
    input wire eid_irq_s          irq_out,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> irq_req == '0)
        else $error("requests not cleared by reset");
    a_standby_quiet: assert property (hw_standby ##1 hw_standby |-> ##2 irq_req == '0)
        else $error("requests present in standby");
    a_vector_range: assert property (irq_out.valid |-> irq_out.vector inside {[5'h0c:5'h11]})
        else $error("vector outside 12 to 17");
    // Four high samples leave no set pending behind the synchroniser
    a_service_clear: assert property (ext_int_input_n[0] [*4] ##0 svc_ack[0] |-> ##2 !irq_req[0])
        else $error("service did not clear flag 0");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer held after accept");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held after accept");
endmodule // eid_detect_checker
bind eid_detect eid_detect_checker #(.NUM_IN(NUM_IN)) chk_u (.clk_sys, .srst, .hw_standby,
    .ext_int_input_n, .svc_ack, .irq_req, .irq_out, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

//--- sim/eid_pin_model.sv
// External devices pulling the active-low request pins
`timescale 1ns/100ps
module eid_pin_model (
    input  wire logic       clk_sys,
    input  wire logic [5:0] assert_req,
    output logic [5:0]      ext_int_input_n
);
    // Pins idle high; changing them on the edge keeps them unrelated to sampling order
    always_ff @(posedge clk_sys) begin
        ext_int_input_n <= ~assert_req;
    end
endmodule // eid_pin_model

//--- sim/testbench.sv
// Self-checking testbench for the external interrupt detector
`timescale 1ns/100ps
`include "eid_defs.svh"
module testbench;
    import eid_pkg::*;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} eid_row_s;
    logic        clk_sys, srst = 1'b1, hw_standby = 1'b0, irq;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [5:0]  drive_low = '0, svc_ack = '0, pins_n, irq_req;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_d;
    logic [1:0]  bresp, rresp, rs;
    eid_irq_s    irq_out;
    int          num_errors = 0, comparisons = 0;
    eid_row_s rows[9] = '{
        '{1'b0, `EID_OFS_FLAG, 32'h0, 32'h0, `EID_RESP_OKAY},
        '{1'b0, `EID_OFS_ENABLE, 32'h0, 32'h0, `EID_RESP_OKAY},
        '{1'b0, `EID_OFS_SENSE, 32'h0, 32'h0, `EID_RESP_OKAY},
        '{1'b1, `EID_OFS_ENABLE, 32'h1ff, 32'h0, `EID_RESP_OKAY},
        '{1'b0, `EID_OFS_ENABLE, 32'h0, 32'hff, `EID_RESP_OKAY},
        '{1'b1, `EID_OFS_SENSE, 32'hc0, 32'h0, `EID_RESP_OKAY},
        '{1'b0, `EID_OFS_SENSE, 32'h0, 32'hc0, `EID_RESP_OKAY},
        '{1'b0, 8'h14, 32'h0, 32'h0, `EID_RESP_SLVERR},
        '{1'b1, 8'h14, 32'h5, 32'h0, `EID_RESP_SLVERR}};
    eid_pin_model pm_u (.clk_sys, .assert_req(drive_low), .ext_int_input_n(pins_n));
    eid_detect dut_u (.clk_sys, .srst, .hw_standby, .ext_int_input_n(pins_n), .svc_ack,
        .irq_req, .irq_out, .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Each channel is released only at the edge that took it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk_sys);
            if (awready && !ad) begin awv <= 1'b0; ad = 1'b1; end
            if (wready && !wd) begin wv <= 1'b0; wd = 1'b1; end
        end
        do @(posedge clk_sys); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arv <= 1'b0;
        do @(posedge clk_sys); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, rd_d, rs);
        chk(rd_d, e);
    endtask
    task automatic ack(input logic [5:0] m);
        svc_ack <= m;
        @(posedge clk_sys);
        svc_ack <= '0;
        cyc(4);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d, rs);
            else rd(rows[i].a, rd_d, rs);
            if (!rows[i].wr) chk(rd_d, rows[i].e);
            chk({30'h0, rs}, {30'h0, rows[i].r});
        end
        wr(`EID_OFS_SENSE, 32'h02, rs);
        drive_low <= 6'h03; cyc(5); drive_low <= 6'h00; cyc(6);
        chk({26'h0, irq_req}, 32'h03);
        wr(`EID_OFS_FLAG, 32'h0, rs);
        rc(`EID_OFS_FLAG, 32'h03);
        wr(`EID_OFS_FLAG, 32'hfe, rs);
        rc(`EID_OFS_FLAG, 32'h02);
        // Held low after service: an edge input must not set again
        drive_low <= 6'h02; cyc(6); ack(6'h02); cyc(2);
        chk({26'h0, irq_req}, 32'h0);
        drive_low <= 6'h01; cyc(6); ack(6'h01);
        chk({26'h0, irq_req}, 32'h01);
        drive_low <= 6'h00; cyc(6); ack(6'h01);
        chk({26'h0, irq_req}, 32'h0);
        drive_low <= 6'h14; cyc(5); drive_low <= 6'h00; cyc(6);
        chk({26'h0, irq_out}, 32'h2e);
        wr(`EID_OFS_ENABLE, 32'h10, rs); cyc(3);
        chk({26'h0, irq_out}, 32'h30);
        wr(`EID_OFS_ENABLE, 32'h0, rs); cyc(3);
        chk({26'h0, irq_req}, 32'h0);
        rc(`EID_OFS_FLAG, 32'h14);
        wr(`EID_OFS_MASK, 32'h01, rs);
        rc(`EID_OFS_STATUS, 32'h03);
        ack(6'h04); cyc(2);
        chk({31'h0, irq}, 32'h0);
        rc(`EID_OFS_STATUS, 32'h02);
        drive_low <= 6'h08; cyc(6); drive_low <= 6'h00;
        chk({31'h0, irq}, 32'h1);
        wr(`EID_OFS_ENABLE, 32'h3f, rs);
        hw_standby <= 1'b1; cyc(2); hw_standby <= 1'b0;
        rc(`EID_OFS_FLAG, 32'h0);
        rc(`EID_OFS_ENABLE, 32'h0);
        rc(`EID_OFS_SENSE, 32'h0);
        wr(`EID_OFS_ENABLE, 32'h3f, rs);
        drive_low <= 6'h01; cyc(5); drive_low <= 6'h00; cyc(6);
        chk({26'h0, irq_out}, 32'h2c);
        srst <= 1'b1; cyc(2); srst <= 1'b0;
        chk({26'h0, irq_out}, 32'h0);
        rc(`EID_OFS_FLAG, 32'h0);
        rc(`EID_OFS_ENABLE, 32'h0);
        tally_and_finish();
    end
endmodule // testbench
